// ===== tdcm_pkg.sv
// tdcm_pkg: constants shared by the tolerant dual channel monitor
// assumes a 200 MHz aclk and one 32-bit AXI4-Lite register port
package tdcm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned TICK_MS      = 10;
  localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_S  = 1000 / TICK_MS;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DISC   = 8'h04;
  localparam logic [7:0] OFS_OFFD   = 8'h08;
  localparam logic [7:0] OFS_ANDLIM = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control bits
  localparam int CB_RUN    = 0;
  localparam int CB_COMPL  = 1;
  localparam int CB_ANDEN  = 2;
  localparam int CB_SUPON  = 3;
  localparam int CB_SUPOFF = 4;
  localparam int CB_GATEEN = 5;
  localparam int CB_STATEN = 6;
  localparam int CB_FLTEN  = 7;

  // field widths and limits, in 10 ms steps or seconds
  localparam int DISC_W = 13;
  localparam int OFFD_W = 10;
  localparam int ANDL_W = 16;
  localparam logic [DISC_W-1:0] DISC_MAX = 13'h1770;
  localparam logic [OFFD_W-1:0] OFFD_MAX = 10'h3E8;
  localparam logic [ANDL_W-1:0] ANDL_MAX = 16'hEA60;

  // reset values
  localparam logic [7:0]        CTRL_RST = 8'h00;
  localparam logic [DISC_W-1:0] DISC_RST = 13'h0000;
  localparam logic [OFFD_W-1:0] OFFD_RST = 10'h000;
  localparam logic [ANDL_W-1:0] ANDL_RST = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // release state machine
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_ON   = 2'b01,
    ST_HOLD = 2'b10
  } tdcm_state_e;

endpackage

// ===== tdcm_top.sv
// tdcm_top: tolerant dual channel monitor with AXI4-Lite registers
// assumes channel pins are asynchronous; bus master is on aclk
`timescale 1ns/1ps

module tdcm_top
  import tdcm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // channel and control pins
  input  wire logic        chan_a_in,
  input  wire logic        chan_b_in,
  input  wire logic        actuator_freed_in,
  input  wire logic        hold_gate_in,
  // monitor outputs
  output logic             grant,
  output logic             timeout_a,
  output logic             timeout_b,
  output logic             fault,
  output logic             status_a,
  output logic             status_b
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [3:0]        pin_s1;
  logic [3:0]        pin_s2;
  logic              af_q;
  logic [7:0]        ctrl;
  logic [DISC_W-1:0] disc_lim;
  logic [OFFD_W-1:0] offd_lim;
  logic [ANDL_W-1:0] and_lim;
  logic              aw_got;
  logic              w_got;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic [31:0]       wr_val;
  logic [31:0]       rd_val;
  logic              rd_ok;
  logic [31:0]       tick_cnt;
  logic              tick;
  tdcm_state_e       state;
  tdcm_state_e       next_state;
  logic              off_a_seen;
  logic              off_b_seen;
  logic              both_off_seen;
  logic              disc_off;
  logic              on_exp;
  logic [DISC_W-1:0] disc_cnt;
  logic [OFFD_W-1:0] off_cnt;
  logic [6:0]        and_sub;
  logic [ANDL_W-1:0] and_sec;
  logic              and_mode;
  logic              to_a;
  logic              to_b;
  logic              flt;
  logic              run_clr;
  logic              a_on;
  logic              b_on;
  logic              af;
  logic              gate_ok;
  logic              both_on;
  logic              disc_exp;
  logic              sup_hit;
  logic              rise_ok;
  logic              grant_rise;
  logic              err_clr;
  logic              and_exp;
  logic              and_set;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      af_q   <= 1'b0;
    end else if (ce) begin
      pin_s1 <= {hold_gate_in, actuator_freed_in, chan_b_in, chan_a_in};
      pin_s2 <= pin_s1;
      af_q   <= pin_s2[2];
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign wr_go = aw_got & w_got & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end else if (!aw_got && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end else if (!w_got && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (aw_addr[7:2] <= OFS_ANDLIM[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // byte lanes merged over the current register value
  always_comb begin
    wr_val = rd_val;
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        wr_val[8*i +: 8] = w_data[8*i +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= CTRL_RST;
      disc_lim <= DISC_RST;
      offd_lim <= OFFD_RST;
      and_lim  <= ANDL_RST;
    end else if (ce && wr_go) begin
      case (aw_addr[7:2])
        OFS_CTRL[7:2]: begin
          ctrl <= wr_val[7:0];
        end
        OFS_DISC[7:2]: begin
          disc_lim <= (wr_val[DISC_W-1:0] > DISC_MAX) ? DISC_MAX : wr_val[DISC_W-1:0];
        end
        OFS_OFFD[7:2]: begin
          offd_lim <= (wr_val[OFFD_W-1:0] > OFFD_MAX) ? OFFD_MAX : wr_val[OFFD_W-1:0];
        end
        OFS_ANDLIM[7:2]: begin
          and_lim <= (wr_val[ANDL_W-1:0] > ANDL_MAX) ? ANDL_MAX : wr_val[ANDL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read mux and read channel
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (wr_go ? aw_addr[7:2] : araddr[7:2])
      OFS_CTRL[7:2]:   rd_val[7:0] = ctrl;
      OFS_DISC[7:2]:   rd_val[DISC_W-1:0] = disc_lim;
      OFS_OFFD[7:2]:   rd_val[OFFD_W-1:0] = offd_lim;
      OFS_ANDLIM[7:2]: rd_val[ANDL_W-1:0] = and_lim;
      OFS_STATUS[7:2]: begin
        rd_val[10:0] = {state, b_on, a_on, status_b, status_a, and_mode,
                        flt, to_b, to_a, grant};
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // reads wait while a write is committing, since the mux is shared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready && !wr_go) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_val;
        rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid && !arready) begin
        arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // 10 ms tick
  // ---------------------------------------------------------------
  // clear on run entry
  // stop clears only on enabled cycles, so a low ce freezes everything
  assign run_clr = !aresetn || (ce && !ctrl[CB_RUN]);
  assign tick    = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0000_0000;
    end else if (ce) begin
      if (run_clr || tick) begin
        tick_cnt <= 32'h0000_0000;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel evaluation
  // ---------------------------------------------------------------
  // equivalent or complementary decode
  assign a_on    = pin_s2[0];
  assign b_on    = ctrl[CB_COMPL] ? ~pin_s2[1] : pin_s2[1];
  assign af      = pin_s2[2];
  assign both_on = a_on & b_on;
  assign gate_ok = ~ctrl[CB_GATEEN] | pin_s2[3];

  assign disc_exp = (disc_lim != '0) && (disc_cnt >= disc_lim) && !and_mode;
  assign sup_hit  = disc_off ? ctrl[CB_SUPOFF] : ctrl[CB_SUPON];

  assign rise_ok = and_mode ? both_on :
                   (both_on & off_a_seen & off_b_seen &
                    ~(ctrl[CB_SUPON] & (disc_exp | on_exp)));
  assign grant_rise = (state == ST_OFF) && rise_ok;
  assign err_clr = grant_rise & both_off_seen;

  // ---------------------------------------------------------------
  // release state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (rise_ok) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (!both_on) begin
          next_state = (gate_ok && offd_lim != '0) ? ST_HOLD : ST_OFF;
        end
      end
      ST_HOLD: begin
        if (both_on) begin
          next_state = ST_ON;
        end else if (!gate_ok || off_cnt >= offd_lim) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (run_clr) begin
      state   <= ST_OFF;
      grant   <= 1'b0;
      off_cnt <= '0;
    end else if (ce) begin
      state <= next_state;
      grant <= (next_state != ST_OFF);
      if (state != ST_HOLD) begin
        off_cnt <= '0;
      end else if (tick && off_cnt != OFFD_MAX) begin
        off_cnt <= off_cnt + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequence memory
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (run_clr) begin
      off_a_seen    <= 1'b0;
      off_b_seen    <= 1'b0;
      both_off_seen <= 1'b0;
    end else if (ce) begin
      if (!a_on) begin
        off_a_seen <= 1'b1;
      end else if (grant_rise) begin
        off_a_seen <= 1'b0;
      end
      if (!b_on) begin
        off_b_seen <= 1'b1;
      end else if (grant_rise) begin
        off_b_seen <= 1'b0;
      end
      if (!a_on && !b_on) begin
        both_off_seen <= 1'b1;
      end else if (grant_rise) begin
        both_off_seen <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // discrepancy supervision
  // ---------------------------------------------------------------
  // a mismatch that starts from both-on is a switch-off mismatch
  always_ff @(posedge aclk) begin
    if (run_clr) begin
      disc_cnt <= '0;
      disc_off <= 1'b0;
      on_exp   <= 1'b0;
    end else if (ce) begin
      if (a_on == b_on) begin
        disc_off <= both_on;
      end
      // switch-on expiry held
      // counter clears once channels agree, so keep it until both off
      if (disc_exp && !disc_off) begin
        on_exp <= 1'b1;
      end else if (!a_on && !b_on) begin
        on_exp <= 1'b0;
      end
      if (a_on == b_on || and_mode) begin
        disc_cnt <= '0;
      end else if (tick && disc_cnt != DISC_MAX) begin
        disc_cnt <= disc_cnt + 1'b1;
      end
    end
  end

  // error latches: a new expiry wins over a clear
  always_ff @(posedge aclk) begin
    if (run_clr) begin
      to_a <= 1'b0;
      to_b <= 1'b0;
      flt  <= 1'b0;
    end else if (ce) begin
      if (disc_exp && sup_hit && (disc_off ? a_on : ~a_on)) begin
        to_a <= 1'b1;
      end else if (err_clr) begin
        to_a <= 1'b0;
      end
      if (disc_exp && sup_hit && (disc_off ? b_on : ~b_on)) begin
        to_b <= 1'b1;
      end else if (err_clr) begin
        to_b <= 1'b0;
      end
      if (disc_exp && sup_hit) begin
        flt <= 1'b1;
      end else if (err_clr) begin
        flt <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AND mode
  // ---------------------------------------------------------------
  // zero means unlimited
  assign and_exp = (and_lim != '0) && (and_sec >= and_lim);
  assign and_set = ctrl[CB_ANDEN] && grant && af_q && !af;

  always_ff @(posedge aclk) begin
    if (run_clr) begin
      and_mode <= 1'b0;
      and_sub  <= 7'h00;
      and_sec  <= '0;
    end else if (ce) begin
      if (and_set) begin
        and_mode <= 1'b1;
      end else if (af || and_exp || !ctrl[CB_ANDEN]) begin
        and_mode <= 1'b0;
      end
      if (!and_mode) begin
        and_sub <= 7'h00;
        and_sec <= '0;
      end else if (tick) begin
        if (and_sub == 7'(TICKS_PER_S - 1)) begin
          and_sub <= 7'h00;
          if (and_sec != ANDL_MAX) begin
            and_sec <= and_sec + 1'b1;
          end
        end else begin
          and_sub <= and_sub + 7'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (run_clr) begin
      timeout_a <= 1'b0;
      timeout_b <= 1'b0;
      fault     <= 1'b0;
      status_a  <= 1'b0;
      status_b  <= 1'b0;
    end else if (ce) begin
      timeout_a <= to_a;
      timeout_b <= to_b;
      fault     <= flt & ctrl[CB_FLTEN];
      if (state != ST_OFF) begin
        status_a <= ctrl[CB_STATEN] & (a_on | (state == ST_HOLD));
        status_b <= ctrl[CB_STATEN] & (b_on | (state == ST_HOLD));
      end else begin
        status_a <= ctrl[CB_STATEN] & a_on & (off_b_seen | and_mode);
        status_b <= ctrl[CB_STATEN] & b_on & (off_a_seen | and_mode);
      end
    end
  end

endmodule

// ===== tdcm_top_chk.sv
// tdcm_top_chk: port-level properties of the dual channel monitor
// assumes CTRL address and data are offered together by the master
`timescale 1ns/1ps
module tdcm_top_chk
  import tdcm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register writes
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  // pins
  input wire logic        chan_a_in,
  input wire logic        chan_b_in,
  input wire logic        hold_gate_in,
  // outputs
  input wire logic        grant,
  input wire logic        timeout_a,
  input wire logic        timeout_b,
  input wire logic        fault,
  input wire logic        status_a,
  input wire logic        status_b
);
  // ----
  // control shadow
  // ----
  // trusted only after seven quiet cycles, so commit latency never matters
  logic [7:0] ctl;
  logic [2:0] sc;
  logic       hs;
  logic       stb;
  assign hs  = awvalid && awready && wvalid && wready;
  assign stb = (sc == 3'h7);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= 8'h00;
      sc  <= 3'h0;
    end else if (hs && awaddr[7:2] == 6'h00) begin
      ctl <= wdata[7:0];
      sc  <= 3'h0;
    end else if (sc != 3'h7) begin
      sc <= sc + 3'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rst;
    $rose(aresetn) |-> !grant && !fault && !timeout_a && !timeout_b;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_wr;
    hs |-> ##2 bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rise;
    stb && ctl[0] && $rose(grant) |->
      $past(chan_a_in, 3) && ($past(chan_b_in, 3) != ctl[1]);
  endproperty
  a_rise: assert property (p_rise) else $error("grant rose without active pins");
  property p_drop;
    stb && ctl[5] && !hold_gate_in && !$past(hold_gate_in, 3) && $fell(chan_a_in)
      |-> ##[1:4] !grant;
  endproperty
  a_drop: assert property (p_drop) else $error("gated switch-off not immediate");
  property p_flt;
    stb && !ctl[7] |-> !fault;
  endproperty
  a_flt: assert property (p_flt) else $error("fault shown while omitted");
  property p_sts;
    stb && !ctl[6] |-> !status_a && !status_b;
  endproperty
  a_sts: assert property (p_sts) else $error("status shown while omitted");
  property p_stop;
    stb && !ctl[0] |-> !grant && !timeout_a && !timeout_b;
  endproperty
  a_stop: assert property (p_stop) else $error("activity while stopped");
  property p_nosup;
    stb && !ctl[3] && !ctl[4] |-> !fault && !timeout_a && !timeout_b;
  endproperty
  a_nosup: assert property (p_nosup) else $error("error without supervision");
  property p_ack;
    timeout_a || timeout_b |-> ctl[3] || ctl[4] || !stb;
  endproperty
  a_ack: assert property (p_ack) else $error("timeout with supervision off");

  c_grant: cover property ($rose(grant));
  c_to_b: cover property ($rose(timeout_b));
  c_fault: cover property ($rose(fault));
endmodule

bind tdcm_top tdcm_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .chan_a_in(chan_a_in), .chan_b_in(chan_b_in),
  .hold_gate_in(hold_gate_in), .grant(grant), .timeout_a(timeout_a),
  .timeout_b(timeout_b), .fault(fault), .status_a(status_a), .status_b(status_b)
);

// ===== tdcm_sw.sv
// tdcm_sw: two-contact safety switch model driving the channel pins
// assumes the bench sets logical contact states after aclk edges
`timescale 1ns/1ps
module tdcm_sw (
  // clock
  input  wire logic       aclk,
  // logical contact states
  input  wire logic       on_a,
  input  wire logic       on_b,
  input  wire logic       compl,
  input  wire logic [3:0] lag,
  // channel pins
  output logic            pin_a = 1'b0,
  output logic            pin_b = 1'b0
);
  logic [15:0] hist = 16'h0000;
  // second contact trails the first by lag+1 cycles, like a slow cam
  always @(posedge aclk) begin
    hist  <= {hist[14:0], on_b};
    pin_a <= on_a;
    pin_b <= hist[lag] ^ compl;
  end
endmodule

// ===== tdcm_top_tb_top.sv
// tdcm_top_tb_top: directed bench for the dual channel monitor
// assumes a 4-cycle tick so every duration stays short
`timescale 1ns/1ps
module tdcm_top_tb_top;
  import tdcm_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0, lag = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        actuator_freed_in = 1'b0, hold_gate_in = 1'b0;
  logic        on_a = 1'b0, on_b = 1'b0, compl = 1'b0, chan_a_in, chan_b_in;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        grant, timeout_a, timeout_b, fault, status_a, status_b;
  int          error_cnt = 0, tests_run = 0, cyc = 0;

  always #2.5 aclk = ~aclk;

  tdcm_top #(.TICK_CYCLES(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .chan_a_in(chan_a_in), .chan_b_in(chan_b_in),
    .actuator_freed_in(actuator_freed_in), .hold_gate_in(hold_gate_in),
    .grant(grant), .timeout_a(timeout_a), .timeout_b(timeout_b), .fault(fault),
    .status_a(status_a), .status_b(status_b));
  tdcm_sw u_sw (.aclk(aclk), .on_a(on_a), .on_b(on_b), .compl(compl), .lag(lag),
    .pin_a(chan_a_in), .pin_b(chan_b_in));

  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic s);
    chk(n, {31'h0, e}, {31'h0, s});
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  // stop then run, so every scenario starts from a run-entry reset
  task automatic cfg(input logic [31:0] c);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, c, RESP_OKAY);
  endtask
  task automatic set(input logic a, input logic b);
    @(posedge aclk);
    on_a <= a;
    on_b <= b;
    cy(8);
  endtask

  task automatic t_regs();
    logic [7:0]  ofs [3];
    logic [31:0] big [3];
    logic [31:0] lim [3];
    ofs = '{OFS_DISC, OFS_OFFD, OFS_ANDLIM};
    big = '{32'h00001771, 32'h000003E9, 32'h0000EA61};
    lim = '{32'h00001770, 32'h000003E8, 32'h0000EA60};
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      rd(ofs[i], 32'h0, RESP_OKAY);
      wr(ofs[i], big[i], RESP_OKAY);
      rd(ofs[i], lim[i], RESP_OKAY);
      wr(ofs[i], 32'h0, RESP_OKAY);
    end
    wr(OFS_STATUS, 32'h1, RESP_SLVERR);
    rd(8'h14, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_equiv();
    cfg(32'hC1);
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    chkb("grant on", 1'b1, grant);
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    chkb("grant one toggle", 1'b0, grant);
    chkb("status_a waiting", 1'b0, status_a);
    set(1'b1, 1'b0);
    set(1'b1, 1'b1);
    chkb("grant staggered", 1'b1, grant);
    set(1'b0, 1'b0);
    lag <= 4'h3;
    set(1'b1, 1'b1);
    cy(4);
    chkb("grant slow b", 1'b1, grant);
    lag <= 4'h0;
  endtask
  task automatic t_compl();
    cfg(32'hC3);
    compl <= 1'b1;
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    chkb("grant compl", 1'b1, grant);
    set(1'b1, 1'b0);
    chkb("compl both high", 1'b0, grant);
    compl <= 1'b0;
  endtask
  task automatic t_disc();
    wr(OFS_DISC, 32'h2, RESP_OKAY);
    cfg(32'hD9);
    set(1'b0, 1'b0);
    set(1'b1, 1'b0);
    cy(40);
    chkb("to_b on", 1'b1, timeout_b);
    chkb("to_a on", 1'b0, timeout_a);
    chkb("fault on", 1'b1, fault);
    set(1'b1, 1'b1);
    chkb("grant expired", 1'b0, grant);
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    chkb("grant clr", 1'b1, grant);
    chkb("to_b clr", 1'b0, timeout_b);
    chkb("fault clr", 1'b0, fault);
    set(1'b0, 1'b1);
    cy(40);
    chkb("to_b off", 1'b1, timeout_b);
    chkb("fault off", 1'b1, fault);
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    wr(OFS_DISC, 32'h0, RESP_OKAY);
    set(1'b0, 1'b1);
    cy(60);
    chkb("to_b zero", 1'b0, timeout_b);
    set(1'b0, 1'b0);
  endtask
  task automatic t_offd();
    wr(OFS_OFFD, 32'h4, RESP_OKAY);
    cfg(32'hE1);
    hold_gate_in <= 1'b1;
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    on_a <= 1'b0;
    cy(6);
    chkb("grant masked", 1'b1, grant);
    chkb("status_a masked", 1'b1, status_a);
    chkb("status_b masked", 1'b1, status_b);
    on_a <= 1'b1;
    cy(30);
    chkb("grant after blip", 1'b1, grant);
    on_a <= 1'b0;
    cy(40);
    chkb("grant off delayed", 1'b0, grant);
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    hold_gate_in <= 1'b0;
    cy(4);
    set(1'b0, 1'b1);
    chkb("grant gate low", 1'b0, grant);
    wr(OFS_OFFD, 32'h0, RESP_OKAY);
  endtask
  task automatic t_and();
    wr(OFS_DISC, 32'h2, RESP_OKAY);
    wr(OFS_ANDLIM, 32'h1, RESP_OKAY);
    cfg(32'hDD);
    actuator_freed_in <= 1'b1;
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    actuator_freed_in <= 1'b0;
    cy(6);
    set(1'b0, 1'b1);
    chkb("and drop", 1'b0, grant);
    cy(30);
    chkb("and no to", 1'b0, timeout_b);
    set(1'b1, 1'b1);
    chkb("and regrant", 1'b1, grant);
    cy(450);
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    chkb("and limit", 1'b0, grant);
    actuator_freed_in <= 1'b1;
    set(1'b0, 1'b0);
    set(1'b1, 1'b1);
    actuator_freed_in <= 1'b0;
    cy(6);
    actuator_freed_in <= 1'b1;
    cy(6);
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    chkb("and left", 1'b0, grant);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    cy(2);
    t_regs();
    t_equiv();
    t_compl();
    t_disc();
    t_offd();
    t_and();
    test_done();
  end

  // hang guard, far above the roughly 1200 cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
endmodule
